// File: hw/mfc_crc16.sv
// serial CCITT checksum engine, one bit per strobe
`default_nettype none
`timescale 1ns/1ps
module mfc_crc16
	import mfc_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        restart_i,
	input  wire logic        stb_i,
	input  wire logic        bit_i,
	output logic      [15:0] crc_o
);
	// restart and a data bit in the same cycle seed the new frame with that bit
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			crc_o <= MFC_CRC_INIT;
		end else if (stb_i) begin
			crc_o <= mfc_crc_step(restart_i ? MFC_CRC_INIT : crc_o, bit_i);
		end else if (restart_i) begin
			crc_o <= MFC_CRC_INIT;
		end
	end
endmodule // mfc_crc16
`default_nettype wire

// File: hw/mfc_frame_delay.sv
// one-frame bit delay line with bypass
`default_nettype none
`timescale 1ns/1ps
module mfc_frame_delay
	import mfc_pkg::*;
(
	input  wire logic                 mclk_i,
	input  wire logic                 rst_i,
	input  wire logic                 buf_i,
	input  wire logic                 stb_i,
	input  wire logic [MFC_LEN_W-1:0] pos_i,
	input  wire logic                 bit_i,
	output logic                      bit_o
);
	logic mem [MFC_MAX_BITS];

	// storing by bit position makes the delay exactly one frame for any length
	always_ff @(posedge mclk_i) begin
		if (stb_i) begin
			mem[pos_i] <= bit_i;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			bit_o <= 1'b0;
		end else if (stb_i) begin
			bit_o <= buf_i ? mem[pos_i] : bit_i;
		end
	end
endmodule // mfc_frame_delay
`default_nettype wire

// File: hw/mfc_pkg.sv
// package for the two-channel minor frame checksum checker
// Function
// - per-channel 16-bit CCITT checksum on minor frames
// - checksum covers all bits except checksum field
// - each channel enabled independently
// - validity decided at frame end
// - unbuffered, validity lags data one frame
// - buffered, data delayed to align validity
// - sample interval sets frames per rate period
// - rate uses only latest interval counts
// - lock mode routes locked channel to chosen output
// - lock mode works with checkers disabled
// - checksum mode routes passing channel to output
// - failed-frame count saturates, cleared by channel reset
// - evaluated-frame count saturates, cleared by channel reset
// - ratio equals failed over evaluated totals
// - frame valid high on pass, low on fail
// - either channel's counters clearable any time
`default_nettype none
package mfc_pkg;
	// ==========================================================
	// checksum
	localparam logic [15:0] MFC_CRC_POLY = 16'h1021;
	localparam logic [15:0] MFC_CRC_INIT = 16'hFFFF;
	localparam int          MFC_CRC_BITS = 16;
	// ==========================================================
	// sizes and counts
	localparam int           MFC_LEN_W    = 13;
	localparam int           MFC_MAX_BITS = 8192;
	localparam int           MFC_CNT_W    = 25;
	localparam logic [24:0]  MFC_CNT_MAX  = 25'h1000000;
	localparam int           MFC_INT_W    = 21;
	localparam logic [4:0]   MFC_EXP_MIN  = 5'h01;
	localparam logic [4:0]   MFC_EXP_MAX  = 5'h14;
	localparam int           MFC_RATIO_W  = 17;
	localparam logic [4:0]   MFC_DIV_LAST = 5'h10;
	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] MFC_OFS_CTRL   = 8'h00;
	localparam logic [7:0] MFC_OFS_SAMP   = 8'h04;
	localparam logic [7:0] MFC_OFS_FLEN   = 8'h08;
	localparam logic [7:0] MFC_OFS_CLEAR  = 8'h0C;
	localparam logic [7:0] MFC_OFS_STATUS = 8'h10;
	localparam logic [7:0] MFC_OFS_CH0    = 8'h20;
	localparam logic [7:0] MFC_OFS_CH1    = 8'h30;
	localparam logic [3:0] MFC_SUB_ERR    = 4'h0;
	localparam logic [3:0] MFC_SUB_FRM    = 4'h4;
	localparam logic [3:0] MFC_SUB_RATIO  = 4'h8;
	localparam logic [3:0] MFC_SUB_FER    = 4'hC;
	// ==========================================================
	// field positions
	localparam int MFC_CTRL_EN0   = 0;
	localparam int MFC_CTRL_EN1   = 1;
	localparam int MFC_CTRL_BUF0  = 2;
	localparam int MFC_CTRL_BUF1  = 3;
	localparam int MFC_CTRL_BEST  = 4;
	localparam int MFC_SAMP_EXP0  = 0;
	localparam int MFC_SAMP_EXP1  = 8;
	localparam int MFC_STAT_LOCK  = 0;
	localparam int MFC_STAT_VALID = 2;
	localparam int MFC_STAT_SEL   = 4;
	// ==========================================================
	// reset values
	localparam logic [5:0]  MFC_CTRL_RST = 6'h00;
	localparam logic [4:0]  MFC_EXP_RST  = 5'h0C;
	localparam logic [12:0] MFC_FLEN_RST = 13'h07FF;
	// ==========================================================
	// types
	typedef enum logic [1:0] {
		MFC_BEST_NONE,
		MFC_BEST_LOCK,
		MFC_BEST_CRC
	} mfc_best_t;

	typedef struct packed {
		logic bit_stb;
		logic bit_val;
		logic frame_start;
		logic lock;
	} mfc_link_t;

	typedef struct packed {
		logic       en;
		logic       buf_on;
		logic [4:0] samp_exp;
	} mfc_chcfg_t;

	function automatic logic [15:0] mfc_crc_step(input logic [15:0] crc, input logic b);
		logic fb;
		fb = crc[15] ^ b;
		return fb ? ({crc[14:0], 1'b0} ^ MFC_CRC_POLY) : {crc[14:0], 1'b0};
	endfunction

	function automatic logic [24:0] mfc_sat_inc(input logic [24:0] v);
		return (v == MFC_CNT_MAX) ? v : v + 25'h0000001;
	endfunction
endpackage
`default_nettype wire

// File: hw/mfc_top.sv
// two-channel minor frame checksum checker with apb registers and best source select
`default_nettype none
`timescale 1ns/1ps
module mfc_top
	import mfc_pkg::*;
(
	input  wire logic             mclk_i,
	input  wire logic             rst_i,
	// apb slave
	input  wire logic [7:0]       paddr_i,
	input  wire logic             psel_i,
	input  wire logic             penable_i,
	input  wire logic             pwrite_i,
	input  wire logic [31:0]      pwdata_i,
	output logic                  pready_o,
	output logic      [31:0]      prdata_o,
	output logic                  pslverr_o,
	// frame synchronizer side
	input  wire mfc_link_t [1:0]  link_i,
	// per-channel outputs
	output logic      [1:0]       data_o,
	output logic      [1:0]       data_stb_o,
	output logic      [1:0]       frame_valid_o,
	// best source
	output logic                  chosen_data_out_o,
	output logic                  chosen_clock_out_o,
	output logic                  chosen_src_o
);
	// ==========================================================
	// configuration registers
	logic [5:0]           ctrl;
	logic [4:0]           samp_exp [2];
	logic [MFC_LEN_W-1:0] frame_len;
	logic [1:0]           clr_pulse;
	mfc_chcfg_t [1:0]     cfg;
	mfc_best_t            best_mode;

	// per-channel state
	logic [MFC_CNT_W-1:0]   err_cnt   [2];
	logic [MFC_CNT_W-1:0]   frm_cnt   [2];
	logic [MFC_CNT_W-1:0]   fer_err   [2];
	logic [MFC_RATIO_W-1:0] ratio     [2];
	logic [1:0]             lock_q;

	logic acc_wr;
	logic acc_setup;

	assign acc_wr    = psel_i & penable_i & pwrite_i;
	assign acc_setup = psel_i & ~penable_i;
	// zero wait states: every access completes in its first access cycle
	assign pready_o  = 1'b1;

	always_comb begin
		best_mode = mfc_best_t'(ctrl[MFC_CTRL_BEST +: 2]);
		cfg[0].en       = ctrl[MFC_CTRL_EN0];
		cfg[1].en       = ctrl[MFC_CTRL_EN1];
		cfg[0].buf_on   = ctrl[MFC_CTRL_BUF0];
		cfg[1].buf_on   = ctrl[MFC_CTRL_BUF1];
		cfg[0].samp_exp = samp_exp[0];
		cfg[1].samp_exp = samp_exp[1];
	end

	function automatic logic [4:0] clamp_exp(input logic [4:0] e);
		return (e < MFC_EXP_MIN) ? MFC_EXP_MIN : ((e > MFC_EXP_MAX) ? MFC_EXP_MAX : e);
	endfunction

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl        <= MFC_CTRL_RST;
			samp_exp[0] <= MFC_EXP_RST;
			samp_exp[1] <= MFC_EXP_RST;
			frame_len   <= MFC_FLEN_RST;
		end else if (acc_wr) begin
			case (paddr_i)
				MFC_OFS_CTRL: ctrl <= pwdata_i[5:0];
				MFC_OFS_SAMP: begin
					samp_exp[0] <= clamp_exp(pwdata_i[MFC_SAMP_EXP0 +: 5]);
					samp_exp[1] <= clamp_exp(pwdata_i[MFC_SAMP_EXP1 +: 5]);
				end
				MFC_OFS_FLEN: frame_len <= pwdata_i[MFC_LEN_W-1:0];
				default: ;
			endcase
		end
	end

	// writing ones to the clear register resets that channel's statistics only
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			clr_pulse <= 2'h0;
		end else begin
			clr_pulse <= (acc_wr && paddr_i == MFC_OFS_CLEAR) ? pwdata_i[1:0] : 2'h0;
		end
	end

	// ==========================================================
	// channels
	logic [1:0] stb_q;

	for (genvar g = 0; g < 2; g++) begin : g_ch
		logic                 stb;
		logic                 start;
		logic                 last;
		logic                 in_data;
		logic                 verdict;
		logic                 pass;
		logic                 synced;
		logic [MFC_LEN_W-1:0] cur_pos;
		logic [MFC_LEN_W-1:0] bit_pos;
		logic [15:0]          rx_crc;
		logic [15:0]          calc_crc;
		logic [MFC_INT_W-1:0] int_frm;
		logic [MFC_CNT_W-1:0] int_err;
		logic [MFC_INT_W-1:0] int_len;
		logic [MFC_INT_W-1:0] int_frm_nx;

		assign stb     = link_i[g].bit_stb;
		assign start   = stb & link_i[g].frame_start;
		assign cur_pos = start ? '0 : bit_pos;
		assign last    = stb & (cur_pos == frame_len - 13'h0001);
		// the trailing checksum field is shifted aside, never fed to the engine
		assign in_data = cur_pos < (frame_len - 13'(MFC_CRC_BITS));
		assign pass    = ({rx_crc[14:0], link_i[g].bit_val} == calc_crc);
		assign verdict = last & synced & cfg[g].en;

		always_ff @(posedge mclk_i or posedge rst_i) begin
			if (rst_i) begin
				bit_pos <= '0;
			end else if (stb) begin
				bit_pos <= last ? '0 : cur_pos + 13'h0001;
			end
		end

		// no verdict before a frame boundary has been seen
		always_ff @(posedge mclk_i or posedge rst_i) begin
			if (rst_i) begin
				synced <= 1'b0;
			end else if (!link_i[g].lock || start) begin
				synced <= link_i[g].lock;
			end
		end

		mfc_crc16 u_crc (
			.mclk_i    (mclk_i),
			.rst_i     (rst_i),
			.restart_i (start),
			.stb_i     (stb & in_data),
			.bit_i     (link_i[g].bit_val),
			.crc_o     (calc_crc)
		);

		always_ff @(posedge mclk_i or posedge rst_i) begin
			if (rst_i) begin
				rx_crc <= 16'h0000;
			end else if (stb && !in_data) begin
				rx_crc <= {rx_crc[14:0], link_i[g].bit_val};
			end
		end

		// the flag holds the last frame's verdict for the whole next frame
		always_ff @(posedge mclk_i or posedge rst_i) begin
			if (rst_i) begin
				frame_valid_o[g] <= 1'b0;
			end else if (verdict) begin
				frame_valid_o[g] <= pass;
			end
		end

		mfc_frame_delay u_dly (
			.mclk_i (mclk_i),
			.rst_i  (rst_i),
			.buf_i  (cfg[g].buf_on),
			.stb_i  (stb),
			.pos_i  (cur_pos),
			.bit_i  (link_i[g].bit_val),
			.bit_o  (data_o[g])
		);

		always_ff @(posedge mclk_i or posedge rst_i) begin
			if (rst_i) begin
				stb_q[g]  <= 1'b0;
				lock_q[g] <= 1'b0;
			end else begin
				stb_q[g]  <= stb;
				lock_q[g] <= link_i[g].lock;
			end
		end

		always_ff @(posedge mclk_i or posedge rst_i) begin
			if (rst_i) begin
				err_cnt[g] <= '0;
				frm_cnt[g] <= '0;
			end else if (clr_pulse[g]) begin
				err_cnt[g] <= '0;
				frm_cnt[g] <= '0;
			end else if (verdict) begin
				frm_cnt[g] <= mfc_sat_inc(frm_cnt[g]);
				if (!pass) begin
					err_cnt[g] <= mfc_sat_inc(err_cnt[g]);
				end
			end
		end

		// interval length is a power of two; the rate is errors per interval
		assign int_len    = MFC_INT_W'(1) << cfg[g].samp_exp;
		assign int_frm_nx = int_frm + 21'h000001;

		always_ff @(posedge mclk_i or posedge rst_i) begin
			if (rst_i) begin
				int_frm    <= '0;
				int_err    <= '0;
				fer_err[g] <= '0;
			end else if (clr_pulse[g]) begin
				int_frm    <= '0;
				int_err    <= '0;
				fer_err[g] <= '0;
			end else if (verdict) begin
				if (int_frm_nx >= int_len) begin
					fer_err[g] <= int_err + (pass ? 25'h0 : 25'h1);
					int_frm    <= '0;
					int_err    <= '0;
				end else begin
					int_frm <= int_frm_nx;
					int_err <= int_err + (pass ? 25'h0 : 25'h1);
				end
			end
		end
	end

	assign data_stb_o = stb_q;

	// ==========================================================
	// best source selection
	logic pick_ch1;

	always_comb begin
		case (best_mode)
			MFC_BEST_LOCK: pick_ch1 = lock_q[1] & ~lock_q[0];
			MFC_BEST_CRC:  pick_ch1 = frame_valid_o[1] & ~frame_valid_o[0];
			default:       pick_ch1 = 1'b0;
		endcase
	end

	// a switch can split a bit period; the chosen clock is re-timed with its data
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			chosen_data_out_o  <= 1'b0;
			chosen_clock_out_o <= 1'b0;
			chosen_src_o       <= 1'b0;
		end else begin
			chosen_data_out_o  <= pick_ch1 ? data_o[1] : data_o[0];
			chosen_clock_out_o <= pick_ch1 ? stb_q[1] : stb_q[0];
			chosen_src_o       <= pick_ch1;
		end
	end

	// ==========================================================
	// ratio divider, shared between channels in turn
	typedef enum logic {
		MFC_DV_LOAD,
		MFC_DV_RUN
	} mfc_dv_state_t;

	mfc_dv_state_t          dv_state;
	logic                   dv_ch;
	logic [4:0]             dv_cnt;
	logic [MFC_CNT_W:0]     dv_rem;
	logic [MFC_CNT_W-1:0]   dv_den;
	logic [MFC_RATIO_W-1:0] dv_q;
	logic                   dv_take;
	logic [MFC_CNT_W:0]     dv_left;

	assign dv_take = dv_rem >= {1'b0, dv_den};
	assign dv_left = dv_take ? dv_rem - {1'b0, dv_den} : dv_rem;

	// result is a 1.16 fixed point fraction, refreshed every few dozen cycles
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			dv_state <= MFC_DV_LOAD;
			dv_ch    <= 1'b0;
			dv_cnt   <= 5'h00;
			dv_rem   <= '0;
			dv_den   <= '0;
			dv_q     <= '0;
			ratio[0] <= '0;
			ratio[1] <= '0;
		end else begin
			case (dv_state)
				MFC_DV_LOAD: begin
					dv_rem   <= {1'b0, err_cnt[dv_ch]};
					dv_den   <= frm_cnt[dv_ch];
					dv_q     <= '0;
					dv_cnt   <= 5'h00;
					dv_state <= MFC_DV_RUN;
				end
				MFC_DV_RUN: begin
					dv_rem <= {dv_left[MFC_CNT_W-1:0], 1'b0};
					dv_q   <= {dv_q[MFC_RATIO_W-2:0], dv_take};
					dv_cnt <= dv_cnt + 5'h01;
					if (dv_cnt == MFC_DIV_LAST) begin
						ratio[dv_ch] <= (dv_den == '0) ? '0 : {dv_q[MFC_RATIO_W-2:0], dv_take};
						dv_ch        <= ~dv_ch;
						dv_state     <= MFC_DV_LOAD;
					end
				end
				default: begin
					dv_state <= MFC_DV_LOAD;
				end
			endcase
		end
	end

	// ==========================================================
	// register read, captured in the setup cycle
	function automatic logic [31:0] ch_word(input logic [3:0] sub, input logic ch);
		case (sub)
			MFC_SUB_ERR:   return 32'(err_cnt[ch]);
			MFC_SUB_FRM:   return 32'(frm_cnt[ch]);
			MFC_SUB_RATIO: return 32'(ratio[ch]);
			MFC_SUB_FER:   return 32'(fer_err[ch]);
			default:       return 32'h00000000;
		endcase
	endfunction

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_o  <= 32'h00000000;
			pslverr_o <= 1'b0;
		end else if (acc_setup) begin
			pslverr_o <= 1'b0;
			case ({paddr_i[7:4], 4'h0})
				MFC_OFS_CH0: begin
					prdata_o <= ch_word(paddr_i[3:0], 1'b0);
				end
				MFC_OFS_CH1: begin
					prdata_o <= ch_word(paddr_i[3:0], 1'b1);
				end
				8'h00: begin
					case (paddr_i)
						MFC_OFS_CTRL:  prdata_o <= {26'h0, ctrl};
						MFC_OFS_SAMP:  prdata_o <= {19'h0, samp_exp[1], 3'h0, samp_exp[0]};
						MFC_OFS_FLEN:  prdata_o <= {19'h0, frame_len};
						MFC_OFS_CLEAR: prdata_o <= 32'h00000000;
						default: begin
							prdata_o  <= 32'h00000000;
							pslverr_o <= 1'b1;
						end
					endcase
				end
				MFC_OFS_STATUS: begin
					prdata_o <= {27'h0, pick_ch1, frame_valid_o, lock_q};
					pslverr_o <= (paddr_i != MFC_OFS_STATUS);
				end
				default: begin
					prdata_o  <= 32'h00000000;
					pslverr_o <= 1'b1;
				end
			endcase
			if (paddr_i[1:0] != 2'h0) begin
				pslverr_o <= 1'b1;
			end
		end
	end
endmodule // mfc_top
`default_nettype wire

// File: verif/mfc_checker_assertions.sv
// concurrent checks on the ports of the two-channel checksum checker
`timescale 1ns/1ps
`default_nettype none
module mfc_checker
	import mfc_pkg::*;
(
	input wire logic            mclk_i,
	input wire logic            rst_i,
	input wire logic [7:0]      paddr_i,
	input wire logic            psel_i,
	input wire logic            penable_i,
	input wire logic            pwrite_i,
	input wire logic [31:0]     pwdata_i,
	input wire mfc_link_t [1:0] link_i,
	input wire logic [1:0]      data_o,
	input wire logic [1:0]      data_stb_o,
	input wire logic [1:0]      frame_valid_o,
	input wire logic            chosen_clock_out_o,
	input wire logic            chosen_src_o
);
	// ==========================================================
	// control shadow
	logic [5:0] ctrl;
	// only completed writes count, the same edge the slave stores them
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl <= 6'h00;
		end else if (psel_i && penable_i && pwrite_i && paddr_i == MFC_OFS_CTRL) begin
			ctrl <= pwdata_i[5:0];
		end
	end
	// ==========================================================
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	chk_stb_delay: assert property (data_stb_o == {$past(link_i[1].bit_stb), $past(link_i[0].bit_stb)})
		else $error("data strobe not one cycle after bit strobe");
	chk_data_live: assert property ((!ctrl[2] && !$past(ctrl[2]) && data_stb_o[0]) |-> data_o[0] == $past(link_i[0].bit_val))
		else $error("unbuffered data does not follow input bit");
	chk_verdict_edge: assert property ($changed(frame_valid_o[1]) |-> $past(link_i[1].bit_stb))
		else $error("frame valid moved without a bit strobe");
	chk_off_holds: assert property ((!ctrl[0] && !$past(ctrl[0])) |-> $stable(frame_valid_o[0]))
		else $error("disabled channel changed its verdict");
	chk_lock_pick: assert property ((ctrl[5:4] == 2'h1 && link_i[1].lock && !link_i[0].lock) [*4] |-> chosen_src_o)
		else $error("locked channel two not chosen");
	chk_crc_pick: assert property ((ctrl[5:4] == 2'h2 && frame_valid_o == 2'b10) [*4] |-> chosen_src_o)
		else $error("passing channel two not chosen");
	chk_default_one: assert property ((ctrl[5:4] == 2'h0 || ctrl[5:4] == 2'h3) [*4] |-> !chosen_src_o)
		else $error("selection off but channel two chosen");
	chk_clock_route: assert property ((chosen_src_o == $past(chosen_src_o)) [*2] |->
		chosen_clock_out_o == $past(data_stb_o[chosen_src_o]))
		else $error("chosen clock not from chosen channel");
endmodule // mfc_checker

bind mfc_top mfc_checker i_mfc_checker (.mclk_i(mclk_i), .rst_i(rst_i), .paddr_i(paddr_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .link_i(link_i), .data_o(data_o),
	.data_stb_o(data_stb_o), .frame_valid_o(frame_valid_o), .chosen_clock_out_o(chosen_clock_out_o),
	.chosen_src_o(chosen_src_o));
`default_nettype wire

// File: verif/mfc_fsync_model.sv
// frame synchronizer model: sends one 32-bit minor frame with checksum per request
`timescale 1ns/1ps
`default_nettype none
module mfc_fsync_model
	import mfc_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        go_i,
	input  wire logic        bad_i,
	input  wire logic        lock_i,
	input  wire logic [15:0] pat_i,
	output mfc_link_t        link_o,
	output logic             busy_o,
	output logic      [31:0] frame_o
);
	logic [31:0] sh;
	logic [5:0]  cnt;
	logic [15:0] crc;
	// ==========================================================
	// checksum over the payload, msb first
	always_comb begin
		crc = 16'hFFFF;
		for (int i = 15; i >= 0; i--) begin
			crc = (crc[15] ^ pat_i[i]) ? ({crc[14:0], 1'b0} ^ 16'h1021) : {crc[14:0], 1'b0};
		end
	end
	assign busy_o = (cnt != 6'h00) || link_o.bit_stb;
	// ==========================================================
	// serialiser
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 6'h00;
			sh <= 32'h00000000;
			frame_o <= 32'h00000000;
			link_o <= '0;
		end else begin
			link_o.lock <= lock_i;
			link_o.bit_stb <= cnt != 6'h00;
			link_o.frame_start <= cnt == 6'h20;
			// idle line toggles its bit every cycle so stale data never looks valid
			link_o.bit_val <= (cnt != 6'h00) ? sh[31] : ~link_o.bit_val;
			if (go_i) begin
				sh <= {pat_i, bad_i ? ~crc : crc};
				frame_o <= {pat_i, bad_i ? ~crc : crc};
				cnt <= 6'h20;
			end else if (cnt != 6'h00) begin
				sh <= {sh[30:0], 1'b0};
				cnt <= cnt - 6'h01;
			end
		end
	end
endmodule // mfc_fsync_model
`default_nettype wire

// File: verif/tb_top.sv
// testbench: register access over apb and framed traffic on both channels
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_top
	import mfc_pkg::*;
;
	logic            mclk_i, rst_i, psel, penable, pwrite, pready, pslverr, rerr, cdata, cclk, csrc, busy0, busy1;
	logic [7:0]      paddr;
	logic [31:0]     pwdata, prdata, rdat, frm0, frm1, cap, fa, capc;
	logic [1:0]      go, bad, lock, data, dstb, fv;
	logic [15:0]     pat;
	mfc_link_t [1:0] link;
	int              n_mismatch = 0;
	int              samples_checked = 0;
	int              cyc = 0;

	mfc_top i_mfc_top (.mclk_i(mclk_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
		.link_i(link), .data_o(data), .data_stb_o(dstb), .frame_valid_o(fv), .chosen_data_out_o(cdata),
		.chosen_clock_out_o(cclk), .chosen_src_o(csrc));
	mfc_fsync_model i_mfc_fsync_model0 (.mclk_i(mclk_i), .rst_i(rst_i), .go_i(go[0]), .bad_i(bad[0]),
		.lock_i(lock[0]), .pat_i(pat), .link_o(link[0]), .busy_o(busy0), .frame_o(frm0));
	mfc_fsync_model i_mfc_fsync_model1 (.mclk_i(mclk_i), .rst_i(rst_i), .go_i(go[1]), .bad_i(bad[1]),
		.lock_i(lock[1]), .pat_i(pat), .link_o(link[1]), .busy_o(busy1), .frame_o(frm1));

	// ==========================================================
	// clock, capture of channel one output, hang guard
	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		if (dstb[0] === 1'b1) begin
			cap <= {cap[30:0], data[0]};
		end
		if (cclk === 1'b1) begin
			capc <= {capc[30:0], cdata};
		end
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	// ==========================================================
	// tasks
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		do @(posedge mclk_i); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		`CHK(rdat, e)
	endtask
	// one frame on both channels; b marks channels whose checksum is inverted
	task automatic send(input logic [1:0] b, input logic [15:0] p);
		@(posedge mclk_i);
		go <= 2'b11;
		bad <= b;
		pat <= p;
		@(posedge mclk_i);
		go <= 2'b00;
		do @(negedge mclk_i); while (busy0 || busy1);
		repeat (4) @(posedge mclk_i);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		rst_i = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		go = 2'b00;
		bad = 2'b00;
		lock = 2'b11;
		pat = 16'h0000;
		repeat (8) @(posedge mclk_i);
		rst_i <= 1'b0;
		rd(MFC_OFS_CTRL, 32'h00000000);
		rd(MFC_OFS_SAMP, 32'h00000C0C);
		rd(MFC_OFS_FLEN, 32'h000007FF);
		rd(8'hFC, 32'h00000000);
		`CHK(rerr, 1'b1)
		apb(1'b1, MFC_OFS_FLEN, 32'h00000020);
		apb(1'b1, MFC_OFS_CTRL, 32'h00000003);
		send(2'b10, 16'h1234);
		rd(MFC_OFS_STATUS, 32'h00000007);
		`CHK(cap, frm0)
		`CHK(capc, frm0)
		rd(MFC_OFS_CH1 + MFC_SUB_ERR, 32'h00000001);
		// interval of two frames after clearing channel one only
		apb(1'b1, MFC_OFS_SAMP, 32'h00000C01);
		apb(1'b1, MFC_OFS_CLEAR, 32'h00000001);
		send(2'b01, 16'hBEEF);
		send(2'b01, 16'h0001);
		rd(MFC_OFS_CH0 + MFC_SUB_FER, 32'h00000002);
		send(2'b00, 16'hFFFF);
		send(2'b01, 16'h8000);
		rd(MFC_OFS_CH0 + MFC_SUB_FER, 32'h00000001);
		repeat (80) @(posedge mclk_i);
		rd(MFC_OFS_CH0 + MFC_SUB_ERR, 32'h00000003);
		rd(MFC_OFS_CH0 + MFC_SUB_FRM, 32'h00000004);
		rd(MFC_OFS_CH0 + MFC_SUB_RATIO, 32'h0000C000);
		rd(MFC_OFS_CH1 + MFC_SUB_ERR, 32'h00000001);
		rd(MFC_OFS_CH1 + MFC_SUB_FRM, 32'h00000005);
		// lock choice with both checkers off
		apb(1'b1, MFC_OFS_CTRL, 32'h00000010);
		lock <= 2'b10;
		send(2'b01, 16'h6C93);
		`CHK(capc, frm1)
		rd(MFC_OFS_STATUS, 32'h0000001A);
		lock <= 2'b11;
		// lock passes the partner's register and the design's before the choice sees it
		repeat (2) @(posedge mclk_i);
		rd(MFC_OFS_STATUS, 32'h0000000B);
		apb(1'b1, MFC_OFS_CTRL, 32'h00000023);
		rd(MFC_OFS_STATUS, 32'h0000001B);
		send(2'b10, 16'h5A5A);
		rd(MFC_OFS_STATUS, 32'h00000007);
		// buffered channel one replays the previous frame
		apb(1'b1, MFC_OFS_CTRL, 32'h00000007);
		send(2'b00, 16'hA5C3);
		fa = frm0;
		send(2'b00, 16'h0F0F);
		`CHK(cap, fa)
		apb(1'b1, MFC_OFS_CTRL, 32'h00000032);
		send(2'b11, 16'h3C3C);
		rd(MFC_OFS_STATUS, 32'h00000007);
		close_out();
	end
endmodule // tb_top
`default_nettype wire
